/* File: rtl/rsd_pkg.sv */
package rsd_pkg;

    // ****************************************************************
    // Bus widths
    // ****************************************************************
    localparam int GADDR_W = 23;
    localparam int DATA_W = 16;

    // ****************************************************************
    // Register window ranges (low, high)
    // ****************************************************************
    localparam logic [22:0] A_PI0_LO = 23'h000000;
    localparam logic [22:0] A_PI0_HI = 23'h000009;
    localparam logic [22:0] A_MM0_LO = 23'h00000a;
    localparam logic [22:0] A_MM0_HI = 23'h00000b;
    localparam logic [22:0] A_PI1_LO = 23'h00000c;
    localparam logic [22:0] A_PI1_HI = 23'h00000d;
    localparam logic [22:0] A_MM1_LO = 23'h000010;
    localparam logic [22:0] A_MM1_HI = 23'h000017;
    localparam logic [22:0] A_PID_LO = 23'h00001a;
    localparam logic [22:0] A_PID_HI = 23'h00001b;
    localparam logic [22:0] A_PI2_LO = 23'h00001c;
    localparam logic [22:0] A_PI2_HI = 23'h00001f;
    localparam logic [22:0] A_DBG_LO = 23'h000020;
    localparam logic [22:0] A_DBG_HI = 23'h00002f;
    localparam logic [22:0] A_CRG_LO = 23'h000034;
    localparam logic [22:0] A_CRG_HI = 23'h00003f;
    localparam logic [22:0] A_TM0_LO = 23'h000040;
    localparam logic [22:0] A_TM0_HI = 23'h00006f;
    localparam logic [22:0] A_CNV_LO = 23'h000070;
    localparam logic [22:0] A_CNV_HI = 23'h00009f;
    localparam logic [22:0] A_PWM_LO = 23'h0000a0;
    localparam logic [22:0] A_PWM_HI = 23'h0000c7;
    localparam logic [22:0] A_AS0_LO = 23'h0000c8;
    localparam logic [22:0] A_AS0_HI = 23'h0000cf;
    localparam logic [22:0] A_AS1_LO = 23'h0000d0;
    localparam logic [22:0] A_AS1_HI = 23'h0000d7;
    localparam logic [22:0] A_SPI_LO = 23'h0000d8;
    localparam logic [22:0] A_SPI_HI = 23'h0000df;
    localparam logic [22:0] A_TWB_LO = 23'h0000e0;
    localparam logic [22:0] A_TWB_HI = 23'h0000e7;
    localparam logic [22:0] A_FLC_LO = 23'h000100;
    localparam logic [22:0] A_FLC_HI = 23'h000113;
    localparam logic [22:0] A_INT_LO = 23'h000120;
    localparam logic [22:0] A_INT_HI = 23'h00012f;
    localparam logic [22:0] A_CN0_LO = 23'h000140;
    localparam logic [22:0] A_CN0_HI = 23'h00017f;
    localparam logic [22:0] A_CN1_LO = 23'h000180;
    localparam logic [22:0] A_CN1_HI = 23'h0001bf;
    localparam logic [22:0] A_MOT_LO = 23'h0001c0;
    localparam logic [22:0] A_MOT_HI = 23'h0001ff;
    localparam logic [22:0] A_DSP_LO = 23'h000200;
    localparam logic [22:0] A_DSP_HI = 23'h00021f;
    localparam logic [22:0] A_SSD_LO = 23'h000220;
    localparam logic [22:0] A_SSD_HI = 23'h00023f;
    localparam logic [22:0] A_PI3_LO = 23'h000240;
    localparam logic [22:0] A_PI3_HI = 23'h00029f;
    localparam logic [22:0] A_TM1_LO = 23'h0002a0;
    localparam logic [22:0] A_TM1_HI = 23'h0002cf;
    localparam logic [22:0] A_VRG_LO = 23'h0002f0;
    localparam logic [22:0] A_VRG_HI = 23'h0002f7;
    localparam logic [22:0] A_REG_TOP = 23'h0007ff;
    localparam logic [22:0] A_UND_LO = 23'h000c00;
    localparam logic [22:0] A_UND_HI = 23'h000fff;
    localparam int SSD_SHIFT = 3;
    localparam logic [1:0] SSD_IDX_MASK = 2'h3;

    // ****************************************************************
    // Global memory windows
    // ****************************************************************
    localparam logic [22:0] A_DF_LO = 23'h100000;
    localparam logic [22:0] A_DF_HI = 23'h13ffff;
    localparam logic [22:0] A_DF_TOP = 23'h101fff;
    localparam int DF_PAGE_SHIFT = 10;
    localparam logic [22:0] A_PF_LO_BIG = 23'h7c0000;
    localparam logic [22:0] A_PF_LO_SMALL = 23'h7e0000;
    localparam logic [22:0] A_PF_HI = 23'h7fffff;
    localparam int PF_PAGE_SHIFT = 14;
    localparam logic [22:0] A_RAM_LO_BIG = 23'h0fd000;
    localparam logic [22:0] A_RAM_LO_SMALL = 23'h0fe000;
    localparam logic [22:0] A_RAM_HI = 23'h0fffff;
    localparam int RAM_PAGE_SHIFT = 12;

    // Part identification value; the figure is arbitrary.
    localparam logic [15:0] PART_ID_DEFAULT = 16'h5a01;

    // ****************************************************************
    // Select codes
    // ****************************************************************
    typedef enum logic [4:0] {
        SEL_NONE, SEL_PORT_INTEGRATION, SEL_MEM_MAP_CTRL, SEL_PART_ID, SEL_DEBUG_BLOCK,
        SEL_CLOCK_RESET_GEN, SEL_FIRST_TIMER, SEL_CONVERTER_BLOCK, SEL_PWM,
        SEL_FIRST_ASYNC_PORT, SEL_SECOND_ASYNC_PORT, SEL_SPI, SEL_TWO_WIRE_BUS,
        SEL_FLASH_CONTROL, SEL_INTERRUPT, SEL_CAN0, SEL_CAN1, SEL_MOTOR, SEL_DISPLAY,
        SEL_STALL_DETECTOR, SEL_SECOND_TIMER, SEL_VOLT_REG, SEL_DATA_FLASH,
        SEL_PROGRAM_FLASH, SEL_RAM
    } rsd_sel_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic cpu;
        logic [22:0] addr;
        logic [15:0] wdata;
    } rsd_req_t;

    typedef struct packed {
        rsd_sel_t sel;
        logic [1:0] ssd_index;
        logic [3:0] page;
        logic write;
        logic [15:0] wdata;
        logic [22:0] addr;
    } rsd_sel_bus_t;

    typedef struct packed {
        logic reserved_hit;
        logic undefined_hit;
        logic illegal_reset_req;
    } rsd_status_t;

endpackage

/* File: rtl/rsd_decoder.sv */
// Overview of operation
// - Port integration selected at 0x0000-09, 0x000C-0D, 0x001C-1F, 0x0240-29F.
// - Memory map control selected at 0x000A-0B and 0x0010-17.
// - Debug at 0x0020-2F, clock/reset gen at 0x0034-3F, 0x0030-33 reserved.
// - Timers, converter and pulse-width modulator each get their fixed range.
// - Each serial unit owns one 8-byte range from 0x00C8 to 0x00E7.
// - Flash control, interrupts, two CAN, motor and display get fixed ranges.
// - Four stall detectors from 0x0220, 8 bytes each; regulator at 0x02F0-2F7.
// - Writes to reserved locations change nothing anywhere.
// - Reads of reserved locations return zero.
// - Reads in 0x0C00-0x0FFF may return any data.
// - CPU access to unimplemented space requests an illegal-address reset.
// - Global 0x10_0000-0x13_FFFF is data flash, implemented to 0x10_1FFF.
// - Program flash starts 0x7C_0000 (16 pages) or 0x7E_0000 (8 pages).
// - RAM starts 0x0F_D000 (3 pages) or 0x0F_E000 (2 pages).
// - Read-only part identification bytes at 0x001A and 0x001B.
module rsd_decoder #(
    parameter bit LARGE_VARIANT = 1'b1,
    parameter logic [15:0] PART_ID = rsd_pkg::PART_ID_DEFAULT
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire rsd_pkg::rsd_req_t i_req,
    input wire logic [15:0] i_module_rdata,
    output rsd_pkg::rsd_sel_bus_t o_sel,
    output logic o_rvalid,
    output logic [15:0] o_rdata,
    output rsd_pkg::rsd_status_t o_status
);
    import rsd_pkg::*;

    // ****************************************************************
    // Address classification
    // ****************************************************************
    function automatic logic in_rng(input logic [22:0] a, input logic [22:0] lo,
                                    input logic [22:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    rsd_sel_t sel_c;
    logic [3:0] page_c;
    logic [1:0] ssd_c;
    logic resv_c;
    logic undef_c;
    logic illegal_c;
    logic [22:0] a;
    logic [22:0] pf_lo;
    logic [22:0] ram_lo;

    always_comb begin
        a = i_req.addr;
        pf_lo = LARGE_VARIANT ? A_PF_LO_BIG : A_PF_LO_SMALL;
        ram_lo = LARGE_VARIANT ? A_RAM_LO_BIG : A_RAM_LO_SMALL;
        sel_c = SEL_NONE;
        page_c = 4'h0;
        ssd_c = 2'h0;
        resv_c = 1'b0;
        undef_c = 1'b0;
        illegal_c = 1'b0;
        if (in_rng(a, A_PI0_LO, A_PI0_HI) || in_rng(a, A_PI1_LO, A_PI1_HI) ||
            in_rng(a, A_PI2_LO, A_PI2_HI) || in_rng(a, A_PI3_LO, A_PI3_HI)) begin
            sel_c = SEL_PORT_INTEGRATION;
        end else if (in_rng(a, A_MM0_LO, A_MM0_HI) || in_rng(a, A_MM1_LO, A_MM1_HI)) begin
            sel_c = SEL_MEM_MAP_CTRL;
        end else if (in_rng(a, A_PID_LO, A_PID_HI)) begin
            sel_c = SEL_PART_ID;
        end else if (in_rng(a, A_DBG_LO, A_DBG_HI)) begin
            sel_c = SEL_DEBUG_BLOCK;
        end else if (in_rng(a, A_CRG_LO, A_CRG_HI)) begin
            sel_c = SEL_CLOCK_RESET_GEN;
        end else if (in_rng(a, A_TM0_LO, A_TM0_HI)) begin
            sel_c = SEL_FIRST_TIMER;
        end else if (in_rng(a, A_CNV_LO, A_CNV_HI)) begin
            sel_c = SEL_CONVERTER_BLOCK;
        end else if (in_rng(a, A_PWM_LO, A_PWM_HI)) begin
            sel_c = SEL_PWM;
        end else if (in_rng(a, A_TM1_LO, A_TM1_HI)) begin
            sel_c = SEL_SECOND_TIMER;
        end else if (in_rng(a, A_AS0_LO, A_AS0_HI)) begin
            sel_c = SEL_FIRST_ASYNC_PORT;
        end else if (in_rng(a, A_AS1_LO, A_AS1_HI)) begin
            sel_c = SEL_SECOND_ASYNC_PORT;
        end else if (in_rng(a, A_SPI_LO, A_SPI_HI)) begin
            sel_c = SEL_SPI;
        end else if (in_rng(a, A_TWB_LO, A_TWB_HI)) begin
            sel_c = SEL_TWO_WIRE_BUS;
        end else if (in_rng(a, A_FLC_LO, A_FLC_HI)) begin
            sel_c = SEL_FLASH_CONTROL;
        end else if (in_rng(a, A_INT_LO, A_INT_HI)) begin
            sel_c = SEL_INTERRUPT;
        end else if (in_rng(a, A_CN0_LO, A_CN0_HI)) begin
            sel_c = SEL_CAN0;
        end else if (in_rng(a, A_CN1_LO, A_CN1_HI)) begin
            sel_c = SEL_CAN1;
        end else if (in_rng(a, A_MOT_LO, A_MOT_HI)) begin
            sel_c = SEL_MOTOR;
        end else if (in_rng(a, A_DSP_LO, A_DSP_HI)) begin
            sel_c = SEL_DISPLAY;
        end else if (in_rng(a, A_SSD_LO, A_SSD_HI)) begin
            sel_c = SEL_STALL_DETECTOR;
            ssd_c = 2'((a - A_SSD_LO) >> SSD_SHIFT) & SSD_IDX_MASK;
        end else if (in_rng(a, A_VRG_LO, A_VRG_HI)) begin
            sel_c = SEL_VOLT_REG;
        end else if (a <= A_REG_TOP) begin
            resv_c = 1'b1;
        end else if (in_rng(a, A_UND_LO, A_UND_HI)) begin
            undef_c = 1'b1;
        end else if (in_rng(a, A_DF_LO, A_DF_TOP)) begin
            sel_c = SEL_DATA_FLASH;
            page_c = 4'((a - A_DF_LO) >> DF_PAGE_SHIFT);
        end else if (in_rng(a, pf_lo, A_PF_HI)) begin
            sel_c = SEL_PROGRAM_FLASH;
            page_c = 4'((a - pf_lo) >> PF_PAGE_SHIFT);
        end else if (in_rng(a, ram_lo, A_RAM_HI)) begin
            sel_c = SEL_RAM;
            page_c = 4'((a - ram_lo) >> RAM_PAGE_SHIFT);
        end else begin
            // Includes the unimplemented part of the data flash window.
            illegal_c = i_req.cpu;
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    rsd_sel_bus_t sel_q, sel_d;
    rsd_status_t status_q, status_d;
    logic rvalid_q, rvalid_d;
    logic [15:0] rdata_q, rdata_d;
    logic rd_pend_q, rd_pend_d;
    logic rd_zero_q, rd_zero_d;
    logic rd_pid_q, rd_pid_d;
    logic pid_lo_q, pid_lo_d;

    always_comb begin
        sel_d = '0;
        status_d = '0;
        rd_pend_d = 1'b0;
        rd_zero_d = 1'b0;
        rd_pid_d = 1'b0;
        pid_lo_d = 1'b0;
        if (i_req.valid) begin
            // Only one select code exists per access, so selects never overlap.
            sel_d.sel = sel_c;
            sel_d.ssd_index = ssd_c;
            sel_d.page = page_c;
            // Part identification is read-only, and a write with no target is dropped.
            sel_d.write = i_req.write && (sel_c != SEL_PART_ID) && (sel_c != SEL_NONE);
            sel_d.wdata = i_req.wdata;
            sel_d.addr = i_req.addr;
            status_d.reserved_hit = resv_c;
            status_d.undefined_hit = undef_c;
            status_d.illegal_reset_req = illegal_c;
            rd_pend_d = !i_req.write;
            // Any read with no module behind it, by either master, returns zero.
            rd_zero_d = (sel_c == SEL_NONE);
            rd_pid_d = (sel_c == SEL_PART_ID);
            pid_lo_d = i_req.addr[0];
        end
        rvalid_d = rd_pend_q;
        if (rd_zero_q) begin
            rdata_d = '0;
        end else if (rd_pid_q) begin
            rdata_d = pid_lo_q ? {8'h00, PART_ID[7:0]} : {8'h00, PART_ID[15:8]};
        end else begin
            rdata_d = i_module_rdata;
        end
        if (!rd_pend_q) begin
            rdata_d = '0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sel_q <= '0;
            status_q <= '0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rd_pend_q <= 1'b0;
            rd_zero_q <= 1'b0;
            rd_pid_q <= 1'b0;
            pid_lo_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            status_q <= status_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rd_pend_q <= rd_pend_d;
            rd_zero_q <= rd_zero_d;
            rd_pid_q <= rd_pid_d;
            pid_lo_q <= pid_lo_d;
        end
    end

    assign o_sel = sel_q;
    assign o_status = status_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;

endmodule

/* File: testbench/rsd_periph_model.sv */
module rsd_periph_model (
    input wire logic i_clk_sys,
    input wire rsd_pkg::rsd_sel_bus_t i_sel,
    output logic [15:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import rsd_pkg::*;
    logic [15:0] junk_q = 16'h0;
    // A released bus carries a pattern that changes every cycle, never a held value.
    always_ff @(posedge i_clk_sys) junk_q <= junk_q + 16'h9e37;
    assign o_rdata = (i_sel.sel != SEL_NONE) ? (i_sel.addr[15:0] ^ 16'ha5c3) : junk_q;
endmodule

/* File: testbench/rsd_decoder_props.sv */
module rsd_decoder_props (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire rsd_pkg::rsd_req_t i_req,
    input wire logic [15:0] i_module_rdata,
    input wire rsd_pkg::rsd_sel_bus_t o_sel,
    input wire logic o_rvalid,
    input wire logic [15:0] o_rdata,
    input wire rsd_pkg::rsd_status_t o_status
);
    timeunit 1ns;
    timeprecision 1ps;
    import rsd_pkg::*;
    logic v;
    logic cpu;
    logic [22:0] a;
    assign v = i_req.valid;
    assign cpu = i_req.cpu;
    assign a = i_req.addr;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);
    a_port_sel: assert property (v && a <= 23'h9 |=> o_sel.sel == SEL_PORT_INTEGRATION)
        else $error("port integration not selected");
    a_mmc_sel: assert property (v && a >= 23'h10 && a <= 23'h17 |=> o_sel.sel == SEL_MEM_MAP_CTRL)
        else $error("memory map control not selected");
    a_hole_quiet: assert property (v && a >= 23'h30 && a <= 23'h33
        |=> o_sel.sel == SEL_NONE && o_status.reserved_hit)
        else $error("reserved hole not flagged");
    a_stall_index: assert property (v && a >= 23'h220 && a <= 23'h23f
        |=> o_sel.sel == SEL_STALL_DETECTOR && o_sel.ssd_index == $past(a[4:3]))
        else $error("stall detector index wrong");
    a_no_stray_write: assert property (o_sel.sel inside {SEL_NONE, SEL_PART_ID} |-> !o_sel.write)
        else $error("write reached a protected place");
    a_hole_reads_zero: assert property (v && !i_req.write && a >= 23'he8 && a <= 23'hff
        |-> ##2 o_rvalid && o_rdata == 16'h0)
        else $error("reserved read not zero");
    a_bad_addr_reset: assert property (v && a >= 23'h800 && a <= 23'hbff
        |=> o_status.illegal_reset_req == $past(cpu))
        else $error("illegal address reset wrong");
    a_one_target: assert property (o_sel.sel != SEL_NONE
        |-> !(o_status.reserved_hit || o_status.illegal_reset_req || o_status.undefined_hit))
        else $error("select together with a fault flag");
    a_data_flash_page: assert property (v && a >= 23'h100000 && a <= 23'h101fff
        |=> o_sel.sel == SEL_DATA_FLASH && o_sel.page == {1'b0, $past(a[12:10])})
        else $error("data flash page wrong");
    a_pflash_page: assert property (v && a >= 23'h7c0000
        |=> o_sel.sel == SEL_PROGRAM_FLASH && o_sel.page == $past(a[17:14]))
        else $error("program flash page wrong");
endmodule

bind rsd_decoder rsd_decoder_props u_props (.i_clk_sys, .i_reset_n, .i_req, .i_module_rdata,
    .o_sel, .o_rvalid, .o_rdata, .o_status);

/* File: testbench/register_space_address_decoder_tb.sv */
module register_space_address_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rsd_pkg::*;
    // Part identification value; the figure is arbitrary.
    localparam logic [15:0] PID = 16'h3c96;
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    rsd_req_t i_req = '0;
    rsd_req_t d1, d2;
    logic [15:0] i_module_rdata;
    rsd_sel_bus_t o_sel;
    logic o_rvalid;
    logic [15:0] o_rdata;
    rsd_status_t o_status;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    int bases[13] = '{32'hfcfff, 32'hfd000, 32'hfe000, 32'hfffff, 32'h100000, 32'h101fff,
        32'h102000, 32'h13ffff, 32'h140000, 32'h7bffff, 32'h7c0000, 32'h7e0000, 32'h7fffff};
    rsd_decoder #(.LARGE_VARIANT(1'b1), .PART_ID(PID)) uut (.i_clk_sys, .i_reset_n, .i_req,
        .i_module_rdata, .o_sel, .o_rvalid, .o_rdata, .o_status);
    rsd_periph_model u_periph (.i_clk_sys, .i_sel(o_sel), .o_rdata(i_module_rdata));
    initial forever #5 i_clk_sys = ~i_clk_sys;

    // ****************************************************************
    // Reference map: class 1 reserved, 2 undefined, 3 unimplemented
    // ****************************************************************
    function automatic void model(input int a, output rsd_sel_t s, output int c, output int pg);
        s = SEL_NONE;
        c = 0;
        pg = 0;
        if (a < 32'h800) begin
            case (a) inside
                [32'h0:32'h9], [32'hc:32'hd], [32'h1c:32'h1f], [32'h240:32'h29f]: s = SEL_PORT_INTEGRATION;
                [32'ha:32'hb], [32'h10:32'h17]: s = SEL_MEM_MAP_CTRL;
                [32'h1a:32'h1b]: s = SEL_PART_ID;
                [32'h20:32'h2f]: s = SEL_DEBUG_BLOCK;
                [32'h34:32'h3f]: s = SEL_CLOCK_RESET_GEN;
                [32'h40:32'h6f]: s = SEL_FIRST_TIMER;
                [32'h70:32'h9f]: s = SEL_CONVERTER_BLOCK;
                [32'ha0:32'hc7]: s = SEL_PWM;
                [32'hc8:32'hcf]: s = SEL_FIRST_ASYNC_PORT;
                [32'hd0:32'hd7]: s = SEL_SECOND_ASYNC_PORT;
                [32'hd8:32'hdf]: s = SEL_SPI;
                [32'he0:32'he7]: s = SEL_TWO_WIRE_BUS;
                [32'h100:32'h113]: s = SEL_FLASH_CONTROL;
                [32'h120:32'h12f]: s = SEL_INTERRUPT;
                [32'h140:32'h17f]: s = SEL_CAN0;
                [32'h180:32'h1bf]: s = SEL_CAN1;
                [32'h1c0:32'h1ff]: s = SEL_MOTOR;
                [32'h200:32'h21f]: s = SEL_DISPLAY;
                [32'h220:32'h23f]: s = SEL_STALL_DETECTOR;
                [32'h2a0:32'h2cf]: s = SEL_SECOND_TIMER;
                [32'h2f0:32'h2f7]: s = SEL_VOLT_REG;
                default: c = 1;
            endcase
            pg = (a >> 3) & 3;
        end else if (a >= 32'hc00 && a <= 32'hfff) c = 2;
        else if (a >= 32'h100000 && a <= 32'h101fff) begin
            s = SEL_DATA_FLASH;
            pg = (a - 32'h100000) >> 10;
        end else if (a >= 32'h7c0000) begin
            s = SEL_PROGRAM_FLASH;
            pg = (a - 32'h7c0000) >> 14;
        end else if (a >= 32'hfd000 && a <= 32'hfffff) begin
            s = SEL_RAM;
            pg = (a - 32'hfd000) >> 12;
        end else c = 3;
    endfunction

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h at %0t", n, exp, seen, $time);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic drive(input int a);
        rsd_req_t r;
        r.valid = ($urandom % 8) != 0;
        r.write = 1'($urandom);
        r.cpu = 1'($urandom);
        r.addr = 23'(a);
        r.wdata = 16'($urandom);
        @(posedge i_clk_sys);
        i_req <= r;
    endtask

    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            d1 <= '0;
            d2 <= '0;
        end else begin
            d1 <= i_req;
            d2 <= d1;
        end
    end

    always @(negedge i_clk_sys) begin
        rsd_sel_t s;
        int c, pg, e;
        logic rd;
        if (!i_reset_n) begin
            check("sel_in_reset", o_sel.sel, SEL_NONE);
            check("rvalid_in_reset", o_rvalid, 1'b0);
        end else begin
            model(d1.addr, s, c, pg);
            check("sel", o_sel.sel, d1.valid ? s : SEL_NONE);
            if (d1.valid) begin
                check("write", o_sel.write, d1.write && !(s inside {SEL_NONE, SEL_PART_ID}));
                check("illegal", o_status.illegal_reset_req, c == 3 && d1.cpu);
                check("undefined", o_status.undefined_hit, c == 2);
                if (c != 2) check("reserved", o_status.reserved_hit, c == 1);
                if (s == SEL_STALL_DETECTOR) check("ssd_index", o_sel.ssd_index, pg);
                if (s >= SEL_DATA_FLASH) check("page", o_sel.page, pg);
            end
            model(d2.addr, s, c, pg);
            rd = d2.valid && !d2.write;
            e = s == SEL_NONE ? 0 : s == SEL_PART_ID ? (d2.addr[0] ? PID[7:0] : PID[15:8])
                : d2.addr[15:0] ^ 16'ha5c3;
            check("rvalid", o_rvalid, rd);
            if (!(rd && c == 2)) check("rdata", o_rdata, rd ? e : 0);
        end
    end

    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(32'h6c38));
        repeat (5) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        for (int a = 0; a < 32'h1000; a++) drive(a);
        $display("register space sweep done");
        for (int i = 0; i < 400; i++) drive(bases[$urandom % 13] + int'($urandom % 9) - 4);
        $display("memory window edges done");
        for (int i = 0; i < 300; i++) drive($urandom);
        $display("random global done");
        @(posedge i_clk_sys);
        i_reset_n <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        for (int a = 32'h18; a < 32'h22; a++) drive(a);
        @(posedge i_clk_sys);
        i_req <= '0;
        repeat (4) @(posedge i_clk_sys);
        $display("reset recovery done");
        finish_test();
    end
endmodule
